// ### rtl/asc_pkg.sv
// constants, field layout and state codes of the converter control block
// assumes a 32-bit apb slave with byte addresses and one word per register
package asc_pkg;

   // ****************************************
   // register map
   // ****************************************
   localparam int ASC_AW = 8;
   localparam int ASC_DW = 32;
   localparam logic [ASC_AW-1:0] ASC_OFS_CTRL0 = 8'h00;
   localparam logic [ASC_AW-1:0] ASC_OFS_CTRL1 = 8'h04;
   localparam logic [ASC_AW-1:0] ASC_OFS_CTRL2 = 8'h08;
   localparam logic [ASC_AW-1:0] ASC_OFS_RESH = 8'h0C;
   localparam logic [ASC_AW-1:0] ASC_OFS_RESL = 8'h10;

   // ****************************************
   // field positions
   // ****************************************
   localparam int ASC_C0_START = 7;
   localparam int ASC_C0_BUSY = 6;
   localparam int ASC_C0_PWR = 5;
   localparam int ASC_C0_FMT = 4;
   localparam int ASC_C0_CHAN = 0;
   localparam int ASC_CHAN_W = 4;
   localparam int ASC_C1_SRC = 5;
   localparam int ASC_C1_REF = 3;
   localparam int ASC_C1_DIV = 0;
   localparam int ASC_DIV_W = 3;
   localparam int ASC_C2_MODE = 6;
   localparam int ASC_C2_RES = 5;
   localparam int ASC_C2_FIX = 1;
   localparam int ASC_C2_TEMP_SENSOR_ENABLE = 0;
   localparam int ASC_CHAN_NONE = 3;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic ASC_FIX_ONE_RST = 1'b1;
   localparam logic [ASC_DW-1:0] ASC_RD_ZERO = 32'h0000_0000;

   // ****************************************
   // codes
   // ****************************************
   localparam logic [2:0] ASC_SRC_EXT0 = 3'h0;
   localparam logic [2:0] ASC_SRC_BG = 3'h1;
   localparam logic [2:0] ASC_SRC_TS = 3'h2;
   localparam logic [2:0] ASC_SRC_GND0 = 3'h3;
   localparam logic [2:0] ASC_SRC_GND1 = 3'h4;
   localparam logic [2:0] ASC_SRC_EXT1 = 3'h5;
   localparam logic [2:0] ASC_SRC_EXT2 = 3'h6;
   localparam logic [2:0] ASC_SRC_BAD = 3'h7;
   localparam logic [1:0] ASC_REF_PIN = 2'h0;
   localparam logic [1:0] ASC_REF_TS = 2'h2;
   localparam logic [1:0] ASC_MODE_LC = 2'h3;

   // ****************************************
   // conversion lengths in converter clocks
   // ****************************************
   localparam int ASC_CNT_W = 6;
   localparam logic [5:0] ASC_TOT_12 = 6'h10;
   localparam logic [5:0] ASC_SMP_12 = 6'h04;
   localparam logic [5:0] ASC_TOT_12_TS = 6'h3A;
   localparam logic [5:0] ASC_SMP_12_TS = 6'h2E;
   localparam logic [5:0] ASC_TOT_10_LC = 6'h0C;
   localparam logic [5:0] ASC_SMP_10_LC = 6'h02;
   localparam logic [5:0] ASC_TOT_10 = 6'h0D;
   localparam logic [5:0] ASC_SMP_10 = 6'h03;
   localparam int ASC_RES_W = 12;

   typedef enum logic [1:0] {
      ASC_IDLE = 2'b00,
      ASC_SAMPLE = 2'b01,
      ASC_CONVERT = 2'b10,
      ASC_STORE = 2'b11
   } asc_state_t;

endpackage

// ### rtl/asc_clk_div.sv
// converter clock divider: one tick every 2**sel system clocks
// assumes sel is static while a conversion runs; restart realigns the phase
`timescale 1ns/100ps
`default_nettype none
module asc_clk_div #(
   parameter int SEL_W = 3,
   parameter int CNT_W = 7
) (
   input wire logic mclk_i,
   input wire logic arst_n_i,
   input wire logic [SEL_W-1:0] sel_i,
   input wire logic restart_i,
   output logic tick_o
);
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] limit;
   logic tick_r;

   always_comb begin
      limit = ~({CNT_W{1'b1}} << sel_i);
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_r <= '0;
         tick_r <= 1'b0;
      end else if (restart_i || cnt_r == limit) begin
         cnt_r <= '0;
         tick_r <= !restart_i;
      end else begin
         cnt_r <= cnt_r + 1'b1;
         tick_r <= 1'b0;
      end
   end

   assign tick_o = tick_r;
endmodule
`default_nettype wire

// ### rtl/asc_ctrl.sv
// converter control: apb registers, input and reference routing, divider,
// conversion sequencer, busy flag, completion request and result formatting
// assumes the analog core delivers its result on conv_data_i, asynchronously
//
// How it works
// R1: source codes route channel, bandgap, sensor, ground
// R2: source code 111 writes are ignored
// R3: sensor input only in 12-bit mode; the code routes the sensor in 10-bit mode too
// R4: reference codes pick pin, supply, sensor reference
// R5: sensor reference only in 12-bit mode; the code selects it in 10-bit mode too
// R6: divider code n divides system clock by 2**n
// R7: two-bit rate mode field selects speed class
// R8: resolution bit zero twelve bits, one ten
// R9: control two bits 4..2 read zero
// R10: software keeps fixed bit at one
// R11: software enables sensor and waits settle time
// R12: sensor use needs 12-bit, rate mode 00
// R13: start bit high then low starts conversion
// R14: busy set at start, cleared at completion
// R15: completion raises the converter request
// R16: software keeps converter clock 0.5 to 10 us
// R17: sensor conversion wants 1 to 2 us clock
// R18: software waits after power enable
// R19: software deselects pins for internal inputs
// R20: software keeps reference pin unconfigured internally
// R21: channel codes 8..15 connect no pin
// R22: 12-bit lasts 16 clocks, sensor 58
// R23: 10-bit lasts 12 low current, else 13
// R24: result stored before busy clears
// R25: start during conversion restarts sampling
`timescale 1ns/100ps
`default_nettype none
module asc_ctrl (
   input wire logic mclk_i,
   input wire logic arst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [asc_pkg::ASC_AW-1:0] paddr_i,
   input wire logic [asc_pkg::ASC_DW-1:0] pwdata_i,
   output logic [asc_pkg::ASC_DW-1:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic [asc_pkg::ASC_RES_W-1:0] conv_data_i,
   output logic power_enable_o,
   output logic temp_sensor_enable_o,
   output logic resolution_10bit_o,
   output logic [1:0] conversion_rate_mode_o,
   output logic [asc_pkg::ASC_CHAN_W-1:0] external_channel_select_o,
   output logic ext_pin_connect_o,
   output logic route_bandgap_o,
   output logic route_sensor_o,
   output logic route_ground_o,
   output logic ref_pin_o,
   output logic ref_supply_o,
   output logic ref_sensor_o,
   output logic sample_o,
   output logic convert_o,
   output logic conv_clk_tick_o,
   output logic conversion_busy_flag_o,
   output logic conv_irq_req_o
);
   import asc_pkg::*;

   // ****************************************
   // register state
   // ****************************************
   logic start_bit_r;
   logic pwr_en_r;
   logic fmt_r;
   logic [ASC_CHAN_W-1:0] chan_r;
   logic [2:0] src_r;
   logic [1:0] ref_r;
   logic [ASC_DIV_W-1:0] div_r;
   logic [1:0] mode_r;
   logic res10_r;
   logic fix_one_r;
   logic temp_sensor_enable_r;
   logic [ASC_RES_W-1:0] res_r;
   logic [ASC_RES_W-1:0] data_meta_r;
   logic [ASC_RES_W-1:0] data_sync_r;

   logic [ASC_DW-1:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic setup;
   logic wr_en;
   logic wr_c0;
   logic wr_c1;
   logic wr_c2;
   logic addr_hit;
   logic start_go;
   logic [ASC_DW-1:0] rd_mux;
   logic [7:0] resh;
   logic [7:0] resl;

   asc_state_t state_r;
   logic [ASC_CNT_W-1:0] cnt_r;
   logic [ASC_CNT_W-1:0] tot_r;
   logic [ASC_CNT_W-1:0] smp_r;
   logic [ASC_CNT_W-1:0] tot_nxt;
   logic [ASC_CNT_W-1:0] smp_nxt;
   logic busy_r;
   logic irq_r;
   logic tick;
   logic tick_r;
   logic done_now;

   // ****************************************
   // apb slave, zero wait states
   // ****************************************
   always_comb begin
      setup = psel_i && !penable_i;
      wr_en = psel_i && penable_i && pwrite_i && pready_r;
      wr_c0 = wr_en && paddr_i == ASC_OFS_CTRL0;
      wr_c1 = wr_en && paddr_i == ASC_OFS_CTRL1;
      wr_c2 = wr_en && paddr_i == ASC_OFS_CTRL2;
      addr_hit = paddr_i == ASC_OFS_CTRL0 || paddr_i == ASC_OFS_CTRL1 ||
                 paddr_i == ASC_OFS_CTRL2 || paddr_i == ASC_OFS_RESH ||
                 paddr_i == ASC_OFS_RESL;
   end

   // result byte placement by resolution and format
   always_comb begin
      if (res10_r) begin
         if (fmt_r) begin
            resh = {6'h00, res_r[9:8]};
            resl = res_r[7:0];
         end else begin
            resh = res_r[9:2];
            resl = {res_r[1:0], 6'h00};
         end
      end else begin
         if (fmt_r) begin
            resh = {4'h0, res_r[11:8]};
            resl = res_r[7:0];
         end else begin
            resh = res_r[11:4];
            resl = {res_r[3:0], 4'h0};
         end
      end
   end

   always_comb begin
      rd_mux = ASC_RD_ZERO;
      unique case (paddr_i)
         ASC_OFS_CTRL0: begin
            rd_mux[ASC_C0_START] = start_bit_r;
            rd_mux[ASC_C0_BUSY] = busy_r;
            rd_mux[ASC_C0_PWR] = pwr_en_r;
            rd_mux[ASC_C0_FMT] = fmt_r;
            rd_mux[ASC_C0_CHAN +: ASC_CHAN_W] = chan_r;
         end
         ASC_OFS_CTRL1: begin
            rd_mux[ASC_C1_SRC +: 3] = src_r;
            rd_mux[ASC_C1_REF +: 2] = ref_r;
            rd_mux[ASC_C1_DIV +: ASC_DIV_W] = div_r;
         end
         ASC_OFS_CTRL2: begin // R9
            rd_mux[ASC_C2_MODE +: 2] = mode_r;
            rd_mux[ASC_C2_RES] = res10_r;
            rd_mux[ASC_C2_FIX] = fix_one_r;
            rd_mux[ASC_C2_TEMP_SENSOR_ENABLE] = temp_sensor_enable_r;
         end
         ASC_OFS_RESH: rd_mux[7:0] = resh;
         ASC_OFS_RESL: rd_mux[7:0] = resl;
         default: rd_mux = ASC_RD_ZERO;
      endcase
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= ASC_RD_ZERO;
      end else begin
         pready_r <= setup;
         pslverr_r <= setup && !addr_hit;
         prdata_r <= setup ? rd_mux : ASC_RD_ZERO;
      end
   end

   // ****************************************
   // control registers
   // ****************************************
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         start_bit_r <= 1'b0;
         pwr_en_r <= 1'b0;
         fmt_r <= 1'b0;
         chan_r <= '0;
      end else if (wr_c0) begin
         start_bit_r <= pwdata_i[ASC_C0_START];
         pwr_en_r <= pwdata_i[ASC_C0_PWR];
         fmt_r <= pwdata_i[ASC_C0_FMT];
         chan_r <= pwdata_i[ASC_C0_CHAN +: ASC_CHAN_W];
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         src_r <= ASC_SRC_EXT0;
         ref_r <= ASC_REF_PIN;
         div_r <= '0;
      end else if (wr_c1) begin
         if (pwdata_i[ASC_C1_SRC +: 3] != ASC_SRC_BAD) begin
            src_r <= pwdata_i[ASC_C1_SRC +: 3]; // R2
         end
         ref_r <= pwdata_i[ASC_C1_REF +: 2];
         div_r <= pwdata_i[ASC_C1_DIV +: ASC_DIV_W];
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mode_r <= 2'h0;
         res10_r <= 1'b0;
         fix_one_r <= ASC_FIX_ONE_RST;
         temp_sensor_enable_r <= 1'b0;
      end else if (wr_c2) begin
         mode_r <= pwdata_i[ASC_C2_MODE +: 2]; // R7
         res10_r <= pwdata_i[ASC_C2_RES];
         fix_one_r <= pwdata_i[ASC_C2_FIX];
         temp_sensor_enable_r <= pwdata_i[ASC_C2_TEMP_SENSOR_ENABLE];
      end
   end

   // ****************************************
   // routing outputs
   // ****************************************
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ext_pin_connect_o <= 1'b0;
         route_bandgap_o <= 1'b0;
         route_sensor_o <= 1'b0;
         route_ground_o <= 1'b0;
         ref_pin_o <= 1'b0;
         ref_supply_o <= 1'b0;
         ref_sensor_o <= 1'b0;
      end else begin
         ext_pin_connect_o <= (src_r == ASC_SRC_EXT0 || src_r == ASC_SRC_EXT1 ||
                               src_r == ASC_SRC_EXT2) && !chan_r[ASC_CHAN_NONE]; // R1 R21
         route_bandgap_o <= src_r == ASC_SRC_BG; // R1
         route_sensor_o <= src_r == ASC_SRC_TS; // R1
         route_ground_o <= src_r == ASC_SRC_GND0 || src_r == ASC_SRC_GND1; // R1
         ref_pin_o <= ref_r == ASC_REF_PIN; // R4
         ref_sensor_o <= ref_r == ASC_REF_TS; // R4
         ref_supply_o <= ref_r[0]; // R4
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         power_enable_o <= 1'b0;
         temp_sensor_enable_o <= 1'b0;
         resolution_10bit_o <= 1'b0;
         conversion_rate_mode_o <= 2'h0;
         external_channel_select_o <= '0;
      end else begin
         power_enable_o <= pwr_en_r;
         temp_sensor_enable_o <= temp_sensor_enable_r;
         resolution_10bit_o <= res10_r; // R8
         conversion_rate_mode_o <= mode_r; // R7
         external_channel_select_o <= chan_r;
      end
   end

   // ****************************************
   // converter clock
   // ****************************************
   asc_clk_div #(
      .SEL_W(ASC_DIV_W),
      .CNT_W(7)
   ) u_div (
      .mclk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .sel_i(div_r), // R6
      .restart_i(start_go),
      .tick_o(tick)
   );

   // ****************************************
   // conversion sequencer
   // ****************************************
   always_comb begin
      start_go = wr_c0 && start_bit_r && !pwdata_i[ASC_C0_START] && pwr_en_r; // R13
      done_now = state_r == ASC_CONVERT && tick && cnt_r == tot_r - 1'b1;
      if (res10_r) begin
         tot_nxt = (mode_r == ASC_MODE_LC) ? ASC_TOT_10_LC : ASC_TOT_10; // R23
         smp_nxt = (mode_r == ASC_MODE_LC) ? ASC_SMP_10_LC : ASC_SMP_10;
      end else begin
         tot_nxt = (src_r == ASC_SRC_TS) ? ASC_TOT_12_TS : ASC_TOT_12; // R22
         smp_nxt = (src_r == ASC_SRC_TS) ? ASC_SMP_12_TS : ASC_SMP_12;
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_r <= ASC_IDLE;
         cnt_r <= '0;
         tot_r <= ASC_TOT_12;
         smp_r <= ASC_SMP_12;
         busy_r <= 1'b0;
      end else if (!pwr_en_r) begin
         state_r <= ASC_IDLE;
         busy_r <= 1'b0;
      end else if (start_go) begin
         state_r <= ASC_SAMPLE; // R25
         cnt_r <= '0;
         tot_r <= tot_nxt;
         smp_r <= smp_nxt;
         busy_r <= 1'b1; // R14
      end else begin
         unique case (state_r)
            ASC_IDLE: begin
               cnt_r <= '0;
            end
            ASC_SAMPLE, ASC_CONVERT: begin
               if (done_now) begin
                  state_r <= ASC_STORE;
               end else if (tick) begin
                  cnt_r <= cnt_r + 1'b1;
                  state_r <= (cnt_r + 1'b1 < smp_r) ? ASC_SAMPLE : ASC_CONVERT;
               end
            end
            ASC_STORE: begin
               state_r <= ASC_IDLE;
               busy_r <= 1'b0; // R14 R24
            end
         endcase
      end
   end

   // result capture one cycle before busy falls
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         data_meta_r <= '0;
         data_sync_r <= '0;
         res_r <= '0;
      end else begin
         data_meta_r <= conv_data_i;
         data_sync_r <= data_meta_r;
         if (done_now && pwr_en_r && !start_go) begin
            res_r <= data_sync_r; // R24
         end
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_r <= 1'b0;
         tick_r <= 1'b0;
         sample_o <= 1'b0;
         convert_o <= 1'b0;
      end else begin
         irq_r <= state_r == ASC_STORE && pwr_en_r && !start_go; // R15
         tick_r <= tick;
         sample_o <= state_r == ASC_SAMPLE;
         convert_o <= state_r == ASC_CONVERT;
      end
   end

   assign prdata_o = prdata_r;
   assign pready_o = pready_r;
   assign pslverr_o = pslverr_r;
   assign conversion_busy_flag_o = busy_r;
   assign conv_irq_req_o = irq_r;
   assign conv_clk_tick_o = tick_r;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!arst_n_i);

   property p_bad_src_kept;
      wr_c1 && pwdata_i[ASC_C1_SRC +: 3] == ASC_SRC_BAD |=> src_r == $past(src_r);
   endproperty
   a_bad_src_kept: assert property (p_bad_src_kept) else $error("source 111 accepted"); // R2

   property p_sensor_route;
      src_r == ASC_SRC_TS |=> route_sensor_o && !route_bandgap_o && !ext_pin_connect_o;
   endproperty
   a_sensor_route: assert property (p_sensor_route) else $error("sensor routing wrong"); // R1

   property p_ref_sensor;
      ref_r == ASC_REF_TS |=> ref_sensor_o && !ref_supply_o && !ref_pin_o;
   endproperty
   a_ref_sensor: assert property (p_ref_sensor) else $error("reference decode wrong"); // R4

   property p_no_pin;
      chan_r[ASC_CHAN_NONE] |=> !ext_pin_connect_o;
   endproperty
   a_no_pin: assert property (p_no_pin) else $error("pin connected for code 8..15"); // R21

   property p_unimpl_zero;
      pready_r && paddr_i == ASC_OFS_CTRL2 |-> prdata_o[4:2] == 3'h0;
   endproperty
   a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bits not zero"); // R9

   property p_start_busy;
      start_go |=> busy_r && state_r == ASC_SAMPLE && cnt_r == '0;
   endproperty
   a_start_busy: assert property (p_start_busy) else $error("start did not restart"); // R14 R25

   property p_store_order;
      done_now && pwr_en_r && !start_go |=> busy_r && res_r == $past(data_sync_r)
         ##1 (!$past(pwr_en_r) || $past(start_go) || (!busy_r && irq_r));
   endproperty
   a_store_order: assert property (p_store_order) else $error("result not before done"); // R24

   property p_irq_cause;
      $rose(irq_r) |-> $past(state_r) == ASC_STORE && !busy_r;
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("request without completion"); // R15

   property p_len_12;
      start_go && !res10_r |=>
         tot_r == ((src_r == ASC_SRC_TS) ? ASC_TOT_12_TS : ASC_TOT_12);
   endproperty
   a_len_12: assert property (p_len_12) else $error("12-bit length wrong"); // R22

   property p_len_10;
      start_go && res10_r |=> tot_r == ((mode_r == ASC_MODE_LC) ? ASC_TOT_10_LC : ASC_TOT_10);
   endproperty
   a_len_10: assert property (p_len_10) else $error("10-bit length wrong"); // R23
endmodule
`default_nettype wire

// ### dv/test_asc_ctrl.sv
// self-checking bench for the converter control block
// assumes the block answers apb on its own; the bench drives every port itself
`timescale 1ns/100ps
`default_nettype none
module test_asc_ctrl;
   import asc_pkg::*;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ASC_AW-1:0] paddr = '0;
   logic [ASC_DW-1:0] pwdata = '0;
   logic [ASC_RES_W-1:0] conv_data = '0;
   logic [ASC_DW-1:0] prdata;
   logic pready, pslverr, pwr, temp_sensor_enable, res10, ext_pin, r_bg, r_ts, r_gnd, f_pin, f_sup, f_ts;
   logic smp, cnv, tick, busy, irq;
   logic [1:0] rate;
   logic [3:0] chan;
   int n_errors = 0;
   int checks = 0;
   int cycles = 0;
   int irq_cnt = 0;

   asc_ctrl asc_ctrl_i (.mclk_i(mclk), .arst_n_i(arst_n), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .conv_data_i(conv_data), .power_enable_o(pwr),
      .temp_sensor_enable_o(temp_sensor_enable), .resolution_10bit_o(res10), .conversion_rate_mode_o(rate),
      .external_channel_select_o(chan), .ext_pin_connect_o(ext_pin), .route_bandgap_o(r_bg),
      .route_sensor_o(r_ts), .route_ground_o(r_gnd), .ref_pin_o(f_pin), .ref_supply_o(f_sup),
      .ref_sensor_o(f_ts), .sample_o(smp), .convert_o(cnv), .conv_clk_tick_o(tick),
      .conversion_busy_flag_o(busy), .conv_irq_req_o(irq));

   always #12.5 mclk = ~mclk;

   always @(posedge mclk) begin
      cycles++;
      if (irq === 1'b1) irq_cnt++;
      if (cycles == 40000) begin
         n_errors++;
         test_done();
      end
   end

   // ****************************************
   // helpers
   // ****************************************
   task automatic test_done();
      if (n_errors == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) chk("pready", 32'h1, 32'h0);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      logic e;
      apb(1'b0, a, 32'h0, q, e);
   endtask

   function automatic logic [6:0] route_exp(input logic [2:0] s, input logic [1:0] r,
                                            input logic [3:0] c);
      route_exp[6] = (s == 3'h0 || s == 3'h5 || s == 3'h6) && !c[3];
      route_exp[5] = s == 3'h1;
      route_exp[4] = s == 3'h2;
      route_exp[3] = s == 3'h3 || s == 3'h4;
      route_exp[2] = r == 2'h0;
      route_exp[1] = r[0];
      route_exp[0] = r == 2'h2;
   endfunction

   function automatic logic [15:0] res_exp(input logic [11:0] v, input logic r10,
                                           input logic f);
      if (!r10) res_exp = f ? {4'h0, v} : {v, 4'h0};
      else res_exp = f ? {6'h0, v[9:0]} : {v[9:0], 6'h0};
   endfunction

   task automatic start(input logic fmt);
      wr(8'h00, {24'h0, 3'b101, fmt, 4'h8});
      wr(8'h00, {24'h0, 3'b001, fmt, 4'h8});
   endtask

   // channel 8 keeps pins off the internal inputs; sensor enabled ahead of use
   task automatic conv(input logic [2:0] s, input logic r10, input logic [1:0] m,
                       input logic [2:0] dv, input logic fmt, input logic again);
      logic [31:0] q;
      logic [11:0] d;
      int t;
      int n;
      int i0;
      int tl;
      int sm;
      int ns;
      int nc;
      int nt;
      tl = r10 ? (m == 2'h3 ? 12 : 13) : (s == 3'h2 ? 58 : 16);
      sm = r10 ? (m == 2'h3 ? 2 : 3) : (s == 3'h2 ? 46 : 4);
      t = tl << dv;
      ns = 0;
      nc = 0;
      nt = 0;
      d = 12'($urandom);
      wr(8'h08, {24'h0, m, r10, 3'h0, 1'b1, s == 3'h2});
      wr(8'h04, {24'h0, s, 2'h1, dv});
      wr(8'h00, {24'h0, 3'b001, fmt, 4'h8});
      repeat (4) @(posedge mclk);
      chk("power enable", 32'h1, {31'h0, pwr});
      conv_data <= d;
      i0 = irq_cnt;
      start(fmt);
      if (again) begin
         repeat (5) @(posedge mclk);
         start(fmt);
      end
      n = 0;
      do begin
         @(posedge mclk);
         n++;
         if (smp === 1'b1) ns++;
         if (cnv === 1'b1) nc++;
         if (tick === 1'b1) nt++;
      end while (busy === 1'b1 && n < 8000);
      if (n < t || n > t + 5) chk("conversion length", 32'(t), 32'(n));
      if (ns < (sm << dv) || ns > (sm << dv) + 2)
         chk("sample clocks", 32'(sm << dv), 32'(ns));
      if (nc < ((tl - sm) << dv) || nc > ((tl - sm) << dv) + 2)
         chk("convert clocks", 32'((tl - sm) << dv), 32'(nc));
      if (nt < tl || nt > tl + 2) chk("converter ticks", 32'(tl), 32'(nt));
      chk("irq at busy fall", 32'h1, {31'h0, irq});
      @(posedge mclk);
      chk("irq pulses", 32'(i0 + 1), 32'(irq_cnt));
      rd(8'h0C, q);
      chk("result high", {24'h0, res_exp(d, r10, fmt)[15:8]}, q);
      rd(8'h10, q);
      chk("result low", {24'h0, res_exp(d, r10, fmt)[7:0]}, q);
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      logic [31:0] q;
      logic e;
      logic [2:0] s;
      logic [2:0] cur;
      logic [2:0] dv;
      logic [1:0] r;
      logic [3:0] c;
      logic [7:0] v;
      void'($urandom(32'hC110));
      repeat (2) @(posedge mclk);
      arst_n <= 1'b1;
      rd(8'h00, q);
      chk("ctrl0 reset", 32'h0, q);
      rd(8'h04, q);
      chk("ctrl1 reset", 32'h0, q);
      rd(8'h08, q);
      chk("ctrl2 reset", 32'h2, q);
      apb(1'b1, 8'h14, 32'hFF, q, e);
      chk("unmapped write error", 32'h1, {31'h0, e});
      apb(1'b0, 8'h14, 32'h0, q, e);
      chk("unmapped read error", 32'h1, {31'h0, e});
      chk("unmapped read data", 32'h0, q);
      wr(8'h0C, 32'hFF);
      rd(8'h0C, q);
      chk("result write ignored", 32'h0, q);
      repeat (8) begin
         v = 8'($urandom);
         v[1] = 1'b1;
         wr(8'h08, {24'h0, v});
         repeat (2) @(posedge mclk);
         chk("rate mode", {30'h0, v[7:6]}, {30'h0, rate});
         chk("resolution", {31'h0, v[5]}, {31'h0, res10});
         chk("sensor enable", {31'h0, v[0]}, {31'h0, temp_sensor_enable});
         rd(8'h08, q);
         chk("ctrl2 readback", {24'h0, v & 8'hE3}, q);
      end
      wr(8'h08, 32'h2);
      cur = 3'h0;
      for (int i = 0; i < 24; i++) begin
         s = i[2:0];
         r = 2'($urandom);
         c = 4'($urandom);
         dv = 3'($urandom);
         if (s != 3'h7) cur = s;
         if (cur >= 3'h1 && cur <= 3'h4) c[3] = 1'b1;
         wr(8'h00, {28'h0, c});
         wr(8'h04, {24'h0, s, r, dv});
         repeat (2) @(posedge mclk);
         chk("routing", {25'h0, route_exp(cur, r, c)},
             {25'h0, ext_pin, r_bg, r_ts, r_gnd, f_pin, f_sup, f_ts});
         chk("channel", {28'h0, c}, {28'h0, chan});
         rd(8'h04, q);
         chk("ctrl1 readback", {24'h0, cur, r, dv}, q);
      end
      wr(8'h00, 32'h80);
      wr(8'h00, 32'h00);
      repeat (40) @(posedge mclk);
      chk("busy with power off", 32'h0, {31'h0, busy});
      conv(3'h0, 1'b0, 2'h0, 3'h5, 1'b0, 1'b0);
      conv(3'h2, 1'b0, 2'h0, 3'h6, 1'b1, 1'b0);
      conv(3'h3, 1'b1, 2'h3, 3'h2, 1'b0, 1'b0);
      conv(3'h5, 1'b1, 2'h1, 3'h0, 1'b1, 1'b0);
      conv(3'h1, 1'b0, 2'h2, 3'h1, 1'b1, 1'b1);
      repeat (6) begin
         s = 3'($urandom_range(6, 0));
         if (s == 3'h2) s = 3'h4;
         conv(s, 1'($urandom), 2'($urandom), 3'($urandom_range(3, 0)), 1'($urandom),
              1'($urandom));
      end
      // reset in the middle of a running conversion
      start(1'b0);
      repeat (3) @(posedge mclk);
      arst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      arst_n <= 1'b1;
      chk("busy after reset", 32'h0, {31'h0, busy});
      rd(8'h08, q);
      chk("ctrl2 after reset", 32'h2, q);
      rd(8'h0C, q);
      chk("result after reset", 32'h0, q);
      test_done();
   end
endmodule
`default_nettype wire
